// file: iesr_ctrl_model.sv
// remote controller model: command driver, answer collector, serial poll
`timescale 1ns/10ps
`default_nettype none
module iesr_ctrl_model (
  // clock
  input  wire logic                 clk_i,
  // command port
  output iesr_pkg::iesr_req_t       req_o,
  input  wire iesr_pkg::iesr_rsp_t  rsp_i,
  // serial poll
  output logic                      spoll_o,
  input  wire logic                 spoll_valid_i,
  input  wire logic [7:0]           spoll_byte_i
);
  import iesr_pkg::*;

  iesr_rsp_t rsp_q[$];

  initial begin
    req_o = '0;
    spoll_o = 1'b0;
  end

  // answers kept in arrival order
  always @(posedge clk_i) begin
    if (rsp_i.valid === 1'b1) begin
      rsp_q.push_back(rsp_i);
    end
  end

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  // request held until the edge that takes it
  task automatic send(input iesr_cmd_t op, input logic [7:0] d);
    req_o = '{valid: 1'b1, op: op, data: d};
    tick();
  endtask

  task automatic idle();
    req_o.valid = 1'b0;
    tick();
  endtask

  task automatic poll(output logic [7:0] b, output logic v);
    spoll_o = 1'b1;
    tick();
    spoll_o = 1'b0;
    v = spoll_valid_i;
    b = spoll_byte_i;
  endtask
endmodule
`default_nettype wire

// file: iesr_errq_mem.sv
// error queue storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module iesr_errq_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic          clk_i,
  // write side
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // read side
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// file: iesr_pkg.sv
// status reporting package: constants, types and the contract list
//Contract
//- event status bits latch occurrences, query readable
//- enabled event bit rising sets summary bit
//- bit0 on op-done when commands finish
//- bit2 on query protocol violations
//- bit3 device error, queue -300..-399 or positive
//- bit4 execution error, queue -200..-299
//- bit5 command error, queue -100..-199
//- bit6 on change to local control
//- bit7 set at power on
//- questionable condition/event parts read zero
//- operation condition live, event since read
//- operation bit0 high while calibrating
//- service request from enabled bits 2,4,5; code also uses enabled bit7
//- serial poll returns the status byte
//- register queries return decimal value
//- each error pushes, each query pops one; code pushes at most one per cycle, none while full
//- op-done with masks 1/32 gives request
//- request is the only self-started activity
//- reading event part clears it, masks kept
//- byte bit5 event summary, bit6 overall
package iesr_pkg;
  localparam int EVT_W  = 8;
  localparam int STAT_W = 16;
  localparam int BCD_W  = 20;
  localparam int CODE_W = 16;
  localparam int ERRQ_DEPTH = 16;
  localparam logic [EVT_W-1:0] EVT_RST = 8'h80;
  localparam logic [EVT_W-1:0] ENA_RST = 8'h00;
  localparam logic [EVT_W-1:0] REQ_ENA_RST = 8'h00;
  localparam logic [EVT_W-1:0] REQ_ENA_USE = 8'hbf;
  // standard event bit positions
  localparam int EB_OPDONE = 0;
  localparam int EB_QRY    = 2;
  localparam int EB_DEV    = 3;
  localparam int EB_EXE    = 4;
  localparam int EB_CMD    = 5;
  localparam int EB_LOCAL  = 6;
  localparam int EB_PWRON  = 7;
  // status byte and operation bit positions
  localparam int SB_QNE  = 2;
  localparam int SB_QSUM = 3;
  localparam int SB_MSG  = 4;
  localparam int SB_EVT  = 5;
  localparam int SB_REQ  = 6;
  localparam int SB_OSUM = 7;
  localparam int OB_CAL  = 0;
  // error code bands (negative) and the zero no-error code
  localparam logic signed [CODE_W-1:0] CODE_NONE   = 16'sh0000;
  localparam logic signed [CODE_W-1:0] CODE_CMD_HI = -16'sh0064;
  localparam logic signed [CODE_W-1:0] CODE_EXE_HI = -16'sh00c8;
  localparam logic signed [CODE_W-1:0] CODE_DEV_HI = -16'sh012c;
  localparam logic signed [CODE_W-1:0] CODE_DEV_LO = -16'sh018f;
  localparam logic signed [CODE_W-1:0] CODE_QRY_HI = -16'sh0190;
  localparam logic signed [CODE_W-1:0] CODE_QRY_LO = -16'sh01f3;

  typedef enum logic [1:0] {
    IESR_E_QRY, IESR_E_DEV, IESR_E_EXE, IESR_E_CMD
  } iesr_ekind_t;

  typedef enum logic [3:0] {
    IESR_C_WR_ENA, IESR_C_WR_RENA, IESR_C_RD_EVT, IESR_C_RD_ENA,
    IESR_C_RD_RENA, IESR_C_RD_SB, IESR_C_RD_QCOND, IESR_C_RD_QEVT,
    IESR_C_RD_OCOND, IESR_C_RD_OEVT, IESR_C_RD_ERR, IESR_C_OPDONE
  } iesr_cmd_t;

  typedef struct packed {
    logic               valid;
    iesr_ekind_t        kind;
    logic [CODE_W-1:0]  code;
  } iesr_err_t;

  typedef struct packed {
    logic               valid;
    iesr_cmd_t          op;
    logic [EVT_W-1:0]   data;
  } iesr_req_t;

  typedef struct packed {
    logic               valid;
    logic               is_err;
    logic               no_err;
    logic [BCD_W-1:0]   bcd;
    logic [CODE_W-1:0]  code;
  } iesr_rsp_t;
endpackage

// file: iesr_top.sv
// event status, status byte, service request and error queue
`timescale 1ns/10ps
`default_nettype none
module iesr_top #(
  parameter int DEPTH = iesr_pkg::ERRQ_DEPTH
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // command / query port
  input  wire iesr_pkg::iesr_req_t  req_i,
  output iesr_pkg::iesr_rsp_t       rsp_o,
  // error and event sources
  input  wire iesr_pkg::iesr_err_t  err_i,
  input  wire logic                 rd_no_query_i,
  input  wire logic                 unread_i,
  input  wire logic                 busy_i,
  input  wire logic                 local_i,
  input  wire logic                 msg_avail_i,
  input  wire logic                 calibrating_i,
  // serial poll and service request
  input  wire logic                 spoll_i,
  output logic                      spoll_valid_o,
  output logic [7:0]                spoll_byte_o,
  output logic                      srq_o
);
  import iesr_pkg::*;

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate

  function automatic logic [BCD_W-1:0] to_bcd(input logic [STAT_W-1:0] v);
    logic [BCD_W+STAT_W-1:0] s;
    s = {{BCD_W{1'b0}}, v};
    for (int i = 0; i < STAT_W; i++) begin
      for (int d = 0; d < BCD_W/4; d++) begin
        if (s[STAT_W+4*d +: 4] > 4'h4) begin
          s[STAT_W+4*d +: 4] = s[STAT_W+4*d +: 4] + 4'h3;
        end
      end
      s = s << 1;
    end
    return s[STAT_W +: BCD_W];
  endfunction

  // out-of-band codes fall back to the band head
  function automatic logic [CODE_W-1:0] fix_code(input iesr_err_t e);
    logic signed [CODE_W-1:0] c;
    logic signed [CODE_W-1:0] hd;
    logic                     ok;
    c  = $signed(e.code);
    hd = CODE_CMD_HI;
    ok = 1'b0;
    unique case (e.kind)
      IESR_E_CMD: begin
        hd = CODE_CMD_HI;
        ok = (c <= CODE_CMD_HI) && (c > CODE_EXE_HI);
      end
      IESR_E_EXE: begin
        hd = CODE_EXE_HI;
        ok = (c <= CODE_EXE_HI) && (c > CODE_DEV_HI);
      end
      IESR_E_DEV: begin
        hd = CODE_DEV_HI;
        ok = ((c <= CODE_DEV_HI) && (c >= CODE_DEV_LO)) || (c > CODE_NONE);
      end
      IESR_E_QRY: begin
        hd = CODE_QRY_HI;
        ok = (c <= CODE_QRY_HI) && (c >= CODE_QRY_LO);
      end
    endcase
    return ok ? e.code : hd;
  endfunction

  // reset release
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // command decode
  logic rd_evt;
  logic rd_oevt;
  logic rd_err;
  logic rd_sb;
  logic is_rd;
  assign rd_evt  = req_i.valid && (req_i.op == IESR_C_RD_EVT);
  assign rd_oevt = req_i.valid && (req_i.op == IESR_C_RD_OEVT);
  assign rd_err  = req_i.valid && (req_i.op == IESR_C_RD_ERR);
  assign rd_sb   = req_i.valid && (req_i.op == IESR_C_RD_SB);
  assign is_rd   = req_i.valid && (req_i.op != IESR_C_WR_ENA) &&
                   (req_i.op != IESR_C_WR_RENA) && (req_i.op != IESR_C_OPDONE);

  // event and mask state
  logic [EVT_W-1:0]  std_evt, std_ena, req_ena, set_vec;
  logic [EVT_W-1:0]  next_std_evt, next_std_ena, next_req_ena;
  logic              op_armed, next_op_armed, op_fire, qry_err;
  logic [STAT_W-1:0] op_cond, op_evt, next_op_cond, next_op_evt;

  assign qry_err = rd_no_query_i | unread_i;
  assign op_fire = op_armed && !busy_i;

  always_comb begin
    set_vec = '0;
    set_vec[EB_OPDONE] = op_fire;
    set_vec[EB_QRY] = qry_err || (err_i.valid && err_i.kind == IESR_E_QRY);
    set_vec[EB_DEV] = err_i.valid && (err_i.kind == IESR_E_DEV);
    set_vec[EB_EXE] = err_i.valid && (err_i.kind == IESR_E_EXE);
    set_vec[EB_CMD] = err_i.valid && (err_i.kind == IESR_E_CMD);
    set_vec[EB_LOCAL] = local_i;
    // latch, clear on read, set wins
    next_std_evt = (rd_evt ? '0 : std_evt) | set_vec;
    next_std_ena = (req_i.valid && req_i.op == IESR_C_WR_ENA) ? req_i.data : std_ena;
    next_req_ena = (req_i.valid && req_i.op == IESR_C_WR_RENA) ? req_i.data : req_ena;
    next_op_armed = op_armed;
    if (op_fire) begin
      next_op_armed = 1'b0;
    end
    if (req_i.valid && req_i.op == IESR_C_OPDONE) begin
      next_op_armed = 1'b1;
    end
    next_op_cond = '0;
    next_op_cond[OB_CAL] = calibrating_i;
    next_op_evt = (rd_oevt ? '0 : op_evt) | (next_op_cond & ~op_cond);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      std_evt  <= EVT_RST;
      std_ena  <= ENA_RST;
      req_ena  <= REQ_ENA_RST;
      op_armed <= 1'b0;
      op_cond  <= '0;
      op_evt   <= '0;
    end else begin
      std_evt  <= next_std_evt;
      std_ena  <= next_std_ena;
      req_ena  <= next_req_ena;
      op_armed <= next_op_armed;
      op_cond  <= next_op_cond;
      op_evt   <= next_op_evt;
    end
  end

  // error queue pointers
  logic [AW-1:0]     wptr, rptr, next_wptr, next_rptr;
  logic [AW:0]       cnt, next_cnt;
  logic              push, push_ok, pop, q_full, q_empty;
  logic [CODE_W-1:0] push_code, mem_rdata;

  assign q_full  = (cnt == (AW+1)'(DEPTH));
  assign q_empty = (cnt == '0);
  assign push      = err_i.valid || qry_err;
  assign push_code = err_i.valid ? fix_code(err_i) : CODE_QRY_HI;
  assign push_ok = push && !q_full;
  assign pop     = rd_err && !q_empty;

  always_comb begin
    next_wptr = push_ok ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
    next_cnt  = cnt;
    if (push_ok && !pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop && !push_ok) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      cnt  <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      cnt  <= next_cnt;
    end
  end

  iesr_errq_mem #(
    .W     (CODE_W),
    .DEPTH (DEPTH)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (push_ok),
    .waddr_i (wptr),
    .wdata_i (push_code),
    .re_i    (pop),
    .raddr_i (rptr),
    .rdata_o (mem_rdata)
  );

  // status byte
  logic [7:0] stat_byte, sb_other;
  logic       evt_sum, req_sum, req_sum_d, next_req_sum_d, next_srq;

  assign evt_sum = |(std_evt & std_ena);
  always_comb begin
    sb_other = '0;
    sb_other[SB_QNE]  = !q_empty;
    sb_other[SB_QSUM] = 1'b0;
    sb_other[SB_MSG]  = msg_avail_i;
    sb_other[SB_EVT]  = evt_sum;
    sb_other[SB_OSUM] = |op_evt;
    // request summary ignores its own enable
    req_sum = |(sb_other & req_ena & REQ_ENA_USE);
    stat_byte = sb_other;
    stat_byte[SB_REQ] = req_sum;
    // only self-started output, raise on rise
    next_srq = srq_o;
    if (rd_sb || spoll_i || !req_sum) begin
      next_srq = 1'b0;
    end
    if (req_sum && !req_sum_d) begin
      next_srq = 1'b1;
    end
    next_req_sum_d = req_sum;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      srq_o     <= 1'b0;
      req_sum_d <= 1'b0;
    end else begin
      srq_o     <= next_srq;
      req_sum_d <= next_req_sum_d;
    end
  end

  // serial poll answer
  logic       next_spoll_valid;
  logic [7:0] next_spoll_byte;
  always_comb begin
    next_spoll_valid = spoll_i;
    next_spoll_byte  = spoll_i ? stat_byte : spoll_byte_o;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spoll_valid_o <= 1'b0;
      spoll_byte_o  <= '0;
    end else begin
      spoll_valid_o <= next_spoll_valid;
      spoll_byte_o  <= next_spoll_byte;
    end
  end

  // two-stage answer: value capture, then format
  logic              p_valid;
  iesr_cmd_t         p_op;
  logic [STAT_W-1:0] p_val;
  logic              p_empty;
  logic              next_p_valid;
  iesr_cmd_t         next_p_op;
  logic [STAT_W-1:0] next_p_val;
  logic              next_p_empty;
  iesr_rsp_t         next_rsp;

  always_comb begin
    next_p_valid = is_rd;
    next_p_op    = is_rd ? req_i.op : p_op;
    next_p_empty = rd_err && q_empty;
    next_p_val   = '0;
    unique case (req_i.op)
      IESR_C_RD_EVT:   next_p_val = {8'h00, std_evt};
      IESR_C_RD_ENA:   next_p_val = {8'h00, std_ena};
      IESR_C_RD_RENA:  next_p_val = {8'h00, req_ena};
      IESR_C_RD_SB:    next_p_val = {8'h00, stat_byte};
      IESR_C_RD_OCOND: next_p_val = op_cond;
      IESR_C_RD_OEVT:  next_p_val = op_evt;
      default:         next_p_val = '0;
    endcase
    next_rsp        = '0;
    next_rsp.valid  = p_valid;
    next_rsp.is_err = p_valid && (p_op == IESR_C_RD_ERR);
    // empty queue answers zero, no error
    next_rsp.no_err = next_rsp.is_err && p_empty;
    if (next_rsp.is_err) begin
      next_rsp.code = p_empty ? CODE_NONE : mem_rdata;
    end else if (p_valid) begin
      next_rsp.bcd = to_bcd(p_val);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      p_valid <= 1'b0;
      p_op    <= IESR_C_RD_EVT;
      p_val   <= '0;
      p_empty <= 1'b0;
      rsp_o   <= '0;
    end else begin
      p_valid <= next_p_valid;
      p_op    <= next_p_op;
      p_val   <= next_p_val;
      p_empty <= next_p_empty;
      rsp_o   <= next_rsp;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  AST_CMD_ERR_FLAG: assert property (
    err_i.valid && err_i.kind == IESR_E_CMD |=> std_evt[EB_CMD])
    else $error("command error not latched");
  AST_OPDONE_FIRE: assert property (
    op_armed && !busy_i |=> std_evt[EB_OPDONE] && !op_armed)
    else $error("op-done not flagged when idle");
  AST_EVT_CLEAR: assert property (
    rd_evt && set_vec == '0 |=> std_evt == '0 && $stable(std_ena))
    else $error("event part not cleared by read");
  AST_SRQ_RISE: assert property (
    $rose(req_sum) |=> srq_o)
    else $error("request missing after summary rise");
  AST_SRQ_CAUSE: assert property (
    srq_o |-> $past(req_sum))
    else $error("request without enabled cause");
  AST_Q_FULL_DROP: assert property (
    push && q_full && !pop |=> q_full && $stable(wptr))
    else $error("full queue disturbed");
  AST_Q_POP: assert property (
    pop && !push_ok |=> cnt == $past(cnt) - 1'b1)
    else $error("pop did not remove one entry");
  AST_Q_EMPTY_RSP: assert property (
    rd_err && q_empty |-> ##2 rsp_o.valid && rsp_o.no_err && rsp_o.code == CODE_NONE)
    else $error("empty queue answer wrong");
  AST_SPOLL: assert property (
    spoll_i |=> spoll_valid_o && spoll_byte_o == $past(stat_byte))
    else $error("serial poll byte wrong");
  AST_CAL_COND: assert property (
    calibrating_i |=> op_cond[OB_CAL] ##1 (op_cond[OB_CAL] || !$past(calibrating_i)))
    else $error("calibration bit not following input");
endmodule
`default_nettype wire

// file: iesr_top_tb.sv
// self-checking bench for the status reporting block
`timescale 1ns/10ps
`default_nettype none
module iesr_top_tb;
  import iesr_pkg::*;

  localparam int DEPTH = 2;
  logic                clk_i;
  logic                rst_b_i;
  iesr_req_t           req_i;
  iesr_rsp_t           rsp_o;
  iesr_err_t           err_i;
  logic                rd_no_query_i;
  logic                unread_i;
  logic                busy_i;
  logic                local_i;
  logic                msg_avail_i;
  logic                calibrating_i;
  logic                spoll_i;
  logic                spoll_valid_o;
  logic [7:0]          spoll_byte_o;
  logic                srq_o;
  int                  miscompares = 0;
  int                  check_count = 0;
  int                  cycles = 0;
  int                  evt, ena, rena, oevt, msg, r1, r2;
  int                  q[$];
  logic [7:0]          pb;
  logic                pv;

  iesr_top #(.DEPTH(DEPTH)) i_iesr_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .rsp_o(rsp_o), .err_i(err_i),
    .rd_no_query_i(rd_no_query_i), .unread_i(unread_i), .busy_i(busy_i),
    .local_i(local_i), .msg_avail_i(msg_avail_i), .calibrating_i(calibrating_i),
    .spoll_i(spoll_i), .spoll_valid_o(spoll_valid_o), .spoll_byte_o(spoll_byte_o),
    .srq_o(srq_o));

  iesr_ctrl_model i_iesr_ctrl_model (
    .clk_i(clk_i), .req_o(req_i), .rsp_i(rsp_o), .spoll_o(spoll_i),
    .spoll_valid_i(spoll_valid_o), .spoll_byte_i(spoll_byte_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  function automatic logic [19:0] to_bcd(input int v);
    logic [19:0] r;
    r = '0;
    for (int i = 0; i < 5; i++) begin
      r[i*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction

  // expected status byte from the model
  function automatic int sb();
    int b;
    b = (q.size() > 0 ? 4 : 0) | (msg << 4) | (int'((evt & ena) != 0) << 5);
    b = b | (int'(oevt != 0) << 7);
    if ((b & rena & 8'hbf) != 0) b = b | 64;
    return b;
  endfunction

  task automatic exp_rsp(input string n, input logic ie, input int v);
    int k;
    iesr_rsp_t r;
    iesr_rsp_t e;
    k = 0;
    while (i_iesr_ctrl_model.rsp_q.size() == 0 && k < 8) begin
      tick();
      k++;
    end
    r = '0;
    if (i_iesr_ctrl_model.rsp_q.size() > 0) r = i_iesr_ctrl_model.rsp_q.pop_front();
    e = '0;
    e.valid = 1'b1;
    e.is_err = ie;
    e.no_err = ie && v == 0;
    if (ie) e.code = 16'(v);
    else e.bcd = to_bcd(v);
    chk(n, r, e);
  endtask

  task automatic inj(input iesr_ekind_t k, input int c);
    err_i = '{valid: 1'b1, kind: k, code: 16'(c)};
    tick();
    evt |= 1 << (k == IESR_E_QRY ? 2 : k == IESR_E_DEV ? 3 : k == IESR_E_EXE ? 4 : 5);
    if (q.size() < DEPTH) q.push_back(c);
  endtask

  initial begin
    rst_b_i = 1'b0;
    err_i = '0;
    rd_no_query_i = 1'b0;
    unread_i = 1'b0;
    busy_i = 1'b0;
    local_i = 1'b0;
    msg_avail_i = 1'b0;
    calibrating_i = 1'b0;
    evt = 8'h80;
    ena = 0;
    rena = 0;
    oevt = 0;
    msg = 0;
    r1 = $urandom(85);
    repeat (4) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    repeat (3) tick();
    // power-on event, clear on read, masks kept
    r1 = $urandom % 256;
    r2 = $urandom % 256;
    i_iesr_ctrl_model.send(IESR_C_RD_EVT, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_RD_EVT, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_WR_ENA, 8'(r1));
    i_iesr_ctrl_model.send(IESR_C_RD_ENA, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_RD_ENA, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_WR_RENA, 8'(r2));
    i_iesr_ctrl_model.send(IESR_C_RD_RENA, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_RD_QCOND, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_RD_QEVT, 8'h00);
    i_iesr_ctrl_model.idle();
    exp_rsp("event", 1'b0, evt);
    evt = 0;
    exp_rsp("event", 1'b0, evt);
    exp_rsp("enable", 1'b0, r1);
    exp_rsp("enable", 1'b0, r1);
    exp_rsp("request enable", 1'b0, r2);
    exp_rsp("quest cond", 1'b0, 0);
    exp_rsp("quest event", 1'b0, 0);
    // op-done held off while busy, then request
    busy_i = 1'b1;
    i_iesr_ctrl_model.send(IESR_C_WR_ENA, 8'h01);
    i_iesr_ctrl_model.send(IESR_C_WR_RENA, 8'h20);
    i_iesr_ctrl_model.send(IESR_C_OPDONE, 8'h00);
    i_iesr_ctrl_model.idle();
    ena = 1;
    rena = 32;
    repeat (4) tick();
    chk("srq busy", srq_o, 1'b0);
    busy_i = 1'b0;
    repeat (4) tick();
    evt = 1;
    chk("srq op done", srq_o, 1'b1);
    i_iesr_ctrl_model.poll(pb, pv);
    chk("poll", {pv, pb}, {1'b1, 8'(sb())});
    tick();
    chk("srq after poll", srq_o, 1'b0);
    i_iesr_ctrl_model.send(IESR_C_RD_EVT, 8'h00);
    i_iesr_ctrl_model.idle();
    exp_rsp("event", 1'b0, evt);
    evt = 0;
    // errors of every kind into a short queue
    i_iesr_ctrl_model.send(IESR_C_WR_ENA, 8'hff);
    i_iesr_ctrl_model.send(IESR_C_WR_RENA, 8'hff);
    i_iesr_ctrl_model.idle();
    ena = 255;
    rena = 255;
    msg_avail_i = 1'b1;
    msg = 1;
    inj(IESR_E_CMD, -101);
    inj(IESR_E_EXE, -201);
    inj(IESR_E_DEV, -301);
    inj(IESR_E_QRY, -410);
    err_i.valid = 1'b0;
    rd_no_query_i = 1'b1;
    tick();
    rd_no_query_i = 1'b0;
    unread_i = 1'b1;
    tick();
    unread_i = 1'b0;
    local_i = 1'b1;
    tick();
    local_i = 1'b0;
    evt |= 8'h44;
    repeat (2) tick();
    chk("srq error", srq_o, 1'b1);
    i_iesr_ctrl_model.send(IESR_C_RD_SB, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_RD_EVT, 8'h00);
    repeat (3) i_iesr_ctrl_model.send(IESR_C_RD_ERR, 8'h00);
    i_iesr_ctrl_model.idle();
    exp_rsp("status byte", 1'b0, sb());
    exp_rsp("event", 1'b0, evt);
    evt = 0;
    exp_rsp("error", 1'b1, q.pop_front());
    exp_rsp("error", 1'b1, q.pop_front());
    exp_rsp("error", 1'b1, 0);
    // calibration condition and event parts
    msg_avail_i = 1'b0;
    msg = 0;
    calibrating_i = 1'b1;
    repeat (3) tick();
    oevt = 1;
    i_iesr_ctrl_model.poll(pb, pv);
    chk("poll op", {pv, pb}, {1'b1, 8'(sb())});
    i_iesr_ctrl_model.send(IESR_C_RD_OCOND, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_RD_OEVT, 8'h00);
    i_iesr_ctrl_model.send(IESR_C_RD_OEVT, 8'h00);
    i_iesr_ctrl_model.idle();
    calibrating_i = 1'b0;
    repeat (2) tick();
    i_iesr_ctrl_model.send(IESR_C_RD_OCOND, 8'h00);
    i_iesr_ctrl_model.idle();
    exp_rsp("op cond", 1'b0, 1);
    exp_rsp("op event", 1'b0, 1);
    exp_rsp("op event", 1'b0, 0);
    exp_rsp("op cond", 1'b0, 0);
    // lone query violation, then an out-of-band execution code
    unread_i = 1'b1;
    tick();
    unread_i = 1'b0;
    err_i = '{valid: 1'b1, kind: IESR_E_EXE, code: 16'hfffb};
    tick();
    err_i.valid = 1'b0;
    i_iesr_ctrl_model.send(IESR_C_RD_EVT, 8'h00);
    repeat (2) i_iesr_ctrl_model.send(IESR_C_RD_ERR, 8'h00);
    i_iesr_ctrl_model.idle();
    exp_rsp("event", 1'b0, 8'h14);
    exp_rsp("error", 1'b1, CODE_QRY_HI);
    exp_rsp("error", 1'b1, CODE_EXE_HI);
    final_report();
  end
endmodule
`default_nettype wire
